/* rtl/adcs_consts.vh */
`ifndef ADCS_CONSTS_VH
`define ADCS_CONSTS_VH

// Register offsets (8-bit bus)
`define ADCS_OFS_CTRL1      8'h00
`define ADCS_OFS_CTRL2      8'h01
`define ADCS_OFS_CTRL3      8'h02
`define ADCS_OFS_STATUS     8'h03
`define ADCS_OFS_RES_HI     8'h04
`define ADCS_OFS_RES_LO     8'h05
`define ADCS_OFS_HTHR_HI    8'h06
`define ADCS_OFS_HTHR_LO    8'h07
`define ADCS_OFS_LTHR_HI    8'h08
`define ADCS_OFS_LTHR_LO    8'h09
`define ADCS_OFS_DMACTL     8'h0a
`define ADCS_OFS_SEL0       8'h0b
`define ADCS_OFS_SEL1       8'h0c
`define ADCS_OFS_SEL2       8'h0d
`define ADCS_OFS_SEL3       8'h0e

// First control register fields
`define ADCS_C1_POWER       0
`define ADCS_C1_START       1
`define ADCS_C1_REPEAT      2
`define ADCS_C1_DONE_IE     3
`define ADCS_C1_ALARM_IE    4
`define ADCS_C1_LOST_IE     5

// Status register fields
`define ADCS_ST_DONE        0
`define ADCS_ST_ALARM       1
`define ADCS_ST_LOST        2

// Channel layout
`define ADCS_NCH            30
`define ADCS_LAST_SLOW      5'h17
`define ADCS_RESET_HTHR     12'hfff
`define ADCS_RESET_LTHR     12'h000

// Trigger edge codes
`define ADCS_EDGE_OFF       2'h0
`define ADCS_EDGE_RISE      2'h1
`define ADCS_EDGE_FALL      2'h2
`define ADCS_EDGE_BOTH      2'h3

// Sampling cycles per 3-bit code
`define ADCS_SMP_0          9'h004
`define ADCS_SMP_1          9'h009
`define ADCS_SMP_2          9'h010
`define ADCS_SMP_3          9'h018
`define ADCS_SMP_4          9'h030
`define ADCS_SMP_5          9'h060
`define ADCS_SMP_6          9'h0c0
`define ADCS_SMP_7          9'h180

`endif

/* rtl/adcs_sequencer.v */
// Contract
// RULE1: Power bit set wakes converter; clearing stops conversion and powers down.
// RULE2: Channels 0-23 use slow sample time; 24-29 use fast sample time.
// RULE3: Single mode converts only the highest selected channel.
// RULE4: Single mode needs DMA disabled; otherwise a start does one scan pass.
// RULE5: Single conversion stores result, sets done flag, interrupts if enabled.
// RULE6: Writing start bit begins conversion; hardware clears start bit itself.
// RULE7: Two-bit source field picks one of three external triggers.
// RULE8: Two-bit edge field picks rising, falling or both trigger edges.
// RULE9: Start events during a conversion are ignored, never queued.
// RULE10: Done flag clears by software write or by reading result low byte.
// RULE11: With no channel selected a conversion still runs and sets done.
// RULE12: Trigger 1 from one of two pins by remap; triggers 2,3 from timers.
// RULE13: Continuous mode steps channels and repeats while repeat and power set.
// RULE14: In scan mode done flag and interrupt come only after last channel.
// RULE15: Clearing repeat mid-sequence finishes sequence through last channel, then stops.
// RULE16: Clock halving bit selects converter clock as system clock or half.
// RULE17: Alarm flag sets when result above high or below low threshold.
// RULE18: In scan mode watchdog checks only the watched channel.
// RULE19: An alarm in scan mode does not stop the sequence.
// RULE20: In scan mode, new result before DMA took previous sets data lost.
// RULE21: Software waits settle time and respects idle delay between conversions.
// RULE22: Software sets edges first, keeps channels and repeat stable mid-conversion.
// RULE23: In scan mode a DMA request issues at each end of conversion.
// RULE24: Bit n of the channel select registers puts channel n in the list.
// RULE25: Each interrupt is flag and enable; common line is OR of all.
`timescale 1ns/1ns
`include "adcs_consts.vh"

module adcs_sequencer (
    input  wire        i_mclk,          // System clock
    input  wire        i_rst,           // Synchronous reset, active high
    input  wire [7:0]  i_addr,          // Register address
    input  wire [7:0]  i_wdata,         // Register write data
    input  wire        i_wr,            // Write strobe
    input  wire        i_rd,            // Read strobe
    output reg  [7:0]  o_rdata,         // Read data, cycle after read strobe
    input  wire        i_trig_pin_dflt, // Default trigger pin
    input  wire        i_trig_pin_alt,  // Alternate trigger pin
    input  wire        i_trig_remap,    // Trigger pin remap bit
    input  wire        i_first_timer_trigger_out,     // First timer trigger out
    input  wire        i_second_timer_trigger_out,     // Second timer trigger out
    output reg         o_power_on,      // Analog power enable
    output wire        o_adc_clk_en,    // Converter clock tick
    output reg  [4:0]  o_conv_channel,  // Channel being converted
    output reg         o_sampling,      // Sampling in progress
    output reg         o_conv_req,      // One-cycle conversion request
    input  wire        i_conv_done,     // Conversion finished pulse
    input  wire [11:0] i_conv_data,     // Converted value
    output reg  [11:0] o_result,        // Latest result
    output reg         o_dma_req,       // DMA request level
    input  wire        i_dma_ack,       // DMA took result
    output wire        o_irq_done,      // Done interrupt
    output wire        o_irq_alarm,     // Alarm interrupt
    output wire        o_irq_lost,      // Data lost interrupt
    output wire        o_irq_any        // Common interrupt
);

    localparam [1:0] ST_IDLE   = 2'h0;
    localparam [1:0] ST_SAMPLE = 2'h1;
    localparam [1:0] ST_CONV   = 2'h2;

    reg [7:0]  ctrl1_reg;
    reg [7:0]  ctrl2_reg;
    reg [7:0]  ctrl3_reg;
    reg        done_reg;
    reg        alarm_reg;
    reg        lost_reg;
    reg [11:0] hthr_reg;
    reg [11:0] lthr_reg;
    reg        dma_off_reg;
    reg [31:0] sel_reg;
    reg [7:0]  shadow_reg;
    reg        shadow_vld_reg;
    reg [1:0]  state_reg;
    reg [8:0]  smp_cnt_reg;
    reg        scan_reg;
    reg        phase_reg;
    reg        trig_prev_reg;

    wire       power    = ctrl1_reg[`ADCS_C1_POWER];
    wire       repeat_b = ctrl1_reg[`ADCS_C1_REPEAT];
    wire [1:0] trig_src = ctrl2_reg[1:0];
    wire [1:0] trig_edg = ctrl2_reg[3:2];
    wire       halve    = ctrl2_reg[4];
    wire [2:0] slow_smp = ctrl2_reg[7:5];
    wire [4:0] watch_ch = ctrl3_reg[4:0];
    wire [2:0] fast_smp = ctrl3_reg[7:5];
    wire [29:0] sel_ch  = sel_reg[29:0];                  // RULE24

    wire wr_c1  = i_wr && (i_addr == `ADCS_OFS_CTRL1);
    wire wr_st  = i_wr && (i_addr == `ADCS_OFS_STATUS);
    wire rd_hi  = i_rd && (i_addr == `ADCS_OFS_RES_HI);
    wire rd_lo  = i_rd && (i_addr == `ADCS_OFS_RES_LO);

    function [4:0] first_from;
        input [29:0] sel;
        input [4:0]  from;
        integer k;
        begin
            first_from = 5'h1f;
            for (k = `ADCS_NCH - 1; k >= 0; k = k - 1) begin
                if (sel[k] && (k >= from))
                    first_from = k[4:0];
            end
        end
    endfunction

    function [4:0] highest;
        input [29:0] sel;
        integer k;
        begin
            highest = 5'h00;
            for (k = 0; k < `ADCS_NCH; k = k + 1) begin
                if (sel[k])
                    highest = k[4:0];
            end
        end
    endfunction

    function [8:0] smp_len;
        input [2:0] code;
        begin
            case (code)
                3'h0:    smp_len = `ADCS_SMP_0;
                3'h1:    smp_len = `ADCS_SMP_1;
                3'h2:    smp_len = `ADCS_SMP_2;
                3'h3:    smp_len = `ADCS_SMP_3;
                3'h4:    smp_len = `ADCS_SMP_4;
                3'h5:    smp_len = `ADCS_SMP_5;
                3'h6:    smp_len = `ADCS_SMP_6;
                default: smp_len = `ADCS_SMP_7;
            endcase
        end
    endfunction

    // Converter clock: every cycle, or every other cycle when halved
    assign o_adc_clk_en = power && (!halve || phase_reg);  // RULE16

    // Trigger selection and edge detection
    reg trig_lvl;
    always @* begin
        case (trig_src)                                    // RULE7
            2'h0:    trig_lvl = i_trig_remap ? i_trig_pin_alt : i_trig_pin_dflt; // RULE12
            2'h1:    trig_lvl = i_first_timer_trigger_out;               // RULE12
            2'h2:    trig_lvl = i_second_timer_trigger_out;               // RULE12
            default: trig_lvl = 1'b0;
        endcase
    end

    reg trig_evt;
    always @* begin
        case (trig_edg)                                    // RULE8
            `ADCS_EDGE_RISE: trig_evt = trig_lvl && !trig_prev_reg;
            `ADCS_EDGE_FALL: trig_evt = !trig_lvl && trig_prev_reg;
            `ADCS_EDGE_BOTH: trig_evt = trig_lvl != trig_prev_reg;
            default:         trig_evt = 1'b0;
        endcase
    end

    wire start_evt   = ctrl1_reg[`ADCS_C1_START] || trig_evt;
    // Busy blocks new starts
    wire start_go    = start_evt && power && (state_reg == ST_IDLE); // RULE9
    wire scan_mode   = repeat_b || !dma_off_reg;           // RULE4
    wire none_sel    = (sel_ch == 30'h0);
    wire [4:0] first_ch = none_sel ? 5'h00 : first_from(sel_ch, 5'h00);
    wire [4:0] start_ch = scan_mode ? first_ch : highest(sel_ch); // RULE3
    wire [4:0] next_ch  = (o_conv_channel == 5'h1d) ? 5'h1f :
                          first_from(sel_ch, o_conv_channel + 5'h01);
    wire more_ch     = scan_reg && (next_ch != 5'h1f) && !none_sel; // RULE13
    wire [2:0] cur_code = (o_conv_channel > `ADCS_LAST_SLOW) ? fast_smp : slow_smp; // RULE2
    wire [8:0] cur_len  = smp_len(cur_code);
    wire conv_end    = (state_reg == ST_CONV) && i_conv_done;
    wire seq_end     = conv_end && !more_ch;
    wire out_of_win  = (i_conv_data > hthr_reg) || (i_conv_data < lthr_reg);
    wire watched     = !scan_reg || (o_conv_channel == watch_ch); // RULE18

    // Sequencer
    always @(posedge i_mclk) begin
        if (i_rst) begin
            state_reg      <= ST_IDLE;
            smp_cnt_reg    <= 9'h000;
            scan_reg       <= 1'b0;
            phase_reg      <= 1'b0;
            trig_prev_reg  <= 1'b0;
            o_conv_channel <= 5'h00;
            o_sampling     <= 1'b0;
            o_conv_req     <= 1'b0;
            o_result       <= 12'h000;
            o_power_on     <= 1'b0;
        end else begin
            phase_reg     <= power ? !phase_reg : 1'b0;
            trig_prev_reg <= trig_lvl;
            o_power_on    <= power;                        // RULE1
            o_conv_req    <= 1'b0;
            if (conv_end)
                o_result <= i_conv_data;                   // RULE5
            if (!power) begin
                state_reg  <= ST_IDLE;                     // RULE1
                o_sampling <= 1'b0;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        if (start_go) begin                // RULE11
                            state_reg      <= ST_SAMPLE;
                            scan_reg       <= scan_mode;
                            o_conv_channel <= start_ch;
                            smp_cnt_reg    <= 9'h000;
                            o_sampling     <= 1'b1;
                        end
                    end
                    ST_SAMPLE: begin
                        if (o_adc_clk_en) begin
                            if (smp_cnt_reg == cur_len - 9'h001) begin
                                state_reg  <= ST_CONV;
                                o_sampling <= 1'b0;
                                o_conv_req <= 1'b1;
                            end else begin
                                smp_cnt_reg <= smp_cnt_reg + 9'h001;
                            end
                        end
                    end
                    ST_CONV: begin
                        if (i_conv_done) begin
                            smp_cnt_reg <= 9'h000;
                            if (more_ch) begin             // RULE19
                                state_reg      <= ST_SAMPLE;
                                o_conv_channel <= next_ch;
                                o_sampling     <= 1'b1;
                            end else if (scan_reg && repeat_b) begin // RULE13
                                state_reg      <= ST_SAMPLE;
                                o_conv_channel <= first_ch;
                                o_sampling     <= 1'b1;
                            end else begin
                                state_reg <= ST_IDLE;      // RULE15
                            end
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Status flags: set beats clear
    always @(posedge i_mclk) begin
        if (i_rst) begin
            done_reg  <= 1'b0;
            alarm_reg <= 1'b0;
            lost_reg  <= 1'b0;
            o_dma_req <= 1'b0;
        end else begin
            if (seq_end)
                done_reg <= 1'b1;                          // RULE14
            else if ((wr_st && i_wdata[`ADCS_ST_DONE]) || rd_lo)
                done_reg <= 1'b0;                          // RULE10
            if (conv_end && watched && out_of_win)
                alarm_reg <= 1'b1;                         // RULE17
            else if (wr_st && i_wdata[`ADCS_ST_ALARM])
                alarm_reg <= 1'b0;
            if (conv_end && scan_reg && !dma_off_reg && o_dma_req && !i_dma_ack)
                lost_reg <= 1'b1;                          // RULE20
            else if (wr_st && i_wdata[`ADCS_ST_LOST])
                lost_reg <= 1'b0;
            if (conv_end && scan_reg && !dma_off_reg)
                o_dma_req <= 1'b1;                         // RULE23
            else if (i_dma_ack)
                o_dma_req <= 1'b0;
        end
    end

    // Register writes
    always @(posedge i_mclk) begin
        if (i_rst) begin
            ctrl1_reg   <= 8'h00;
            ctrl2_reg   <= 8'h00;
            ctrl3_reg   <= 8'h00;
            hthr_reg    <= `ADCS_RESET_HTHR;
            lthr_reg    <= `ADCS_RESET_LTHR;
            dma_off_reg <= 1'b0;
            sel_reg     <= 32'h00000000;
        end else begin
            // Start bit self-clears one cycle after it is written
            ctrl1_reg[`ADCS_C1_START] <= 1'b0;             // RULE6
            if (wr_c1)
                ctrl1_reg <= {2'h0, i_wdata[5:0]};
            if (i_wr) begin
                case (i_addr)
                    `ADCS_OFS_CTRL2:   ctrl2_reg        <= i_wdata;
                    `ADCS_OFS_CTRL3:   ctrl3_reg        <= i_wdata;
                    `ADCS_OFS_HTHR_HI: hthr_reg[11:8]   <= i_wdata[3:0];
                    `ADCS_OFS_HTHR_LO: hthr_reg[7:0]    <= i_wdata;
                    `ADCS_OFS_LTHR_HI: lthr_reg[11:8]   <= i_wdata[3:0];
                    `ADCS_OFS_LTHR_LO: lthr_reg[7:0]    <= i_wdata;
                    `ADCS_OFS_DMACTL:  dma_off_reg      <= i_wdata[0];
                    `ADCS_OFS_SEL0:    sel_reg[7:0]     <= i_wdata;
                    `ADCS_OFS_SEL1:    sel_reg[15:8]    <= i_wdata;
                    `ADCS_OFS_SEL2:    sel_reg[23:16]   <= i_wdata;
                    `ADCS_OFS_SEL3:    sel_reg[31:24]   <= {2'h0, i_wdata[5:0]};
                    default: begin
                    end
                endcase
            end
        end
    end

    // Read path with low-byte shadow taken at high-byte read
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_rdata        <= 8'h00;
            shadow_reg     <= 8'h00;
            shadow_vld_reg <= 1'b0;
        end else begin
            if (rd_hi) begin
                shadow_reg     <= o_result[7:0];
                shadow_vld_reg <= 1'b1;
            end else if (rd_lo) begin
                shadow_vld_reg <= 1'b0;
            end
            if (i_rd) begin
                case (i_addr)
                    `ADCS_OFS_CTRL1:   o_rdata <= ctrl1_reg;
                    `ADCS_OFS_CTRL2:   o_rdata <= ctrl2_reg;
                    `ADCS_OFS_CTRL3:   o_rdata <= ctrl3_reg;
                    `ADCS_OFS_STATUS:  o_rdata <= {5'h00, lost_reg, alarm_reg, done_reg};
                    `ADCS_OFS_RES_HI:  o_rdata <= {4'h0, o_result[11:8]};
                    `ADCS_OFS_RES_LO:  o_rdata <= shadow_vld_reg ? shadow_reg : o_result[7:0];
                    `ADCS_OFS_HTHR_HI: o_rdata <= {4'h0, hthr_reg[11:8]};
                    `ADCS_OFS_HTHR_LO: o_rdata <= hthr_reg[7:0];
                    `ADCS_OFS_LTHR_HI: o_rdata <= {4'h0, lthr_reg[11:8]};
                    `ADCS_OFS_LTHR_LO: o_rdata <= lthr_reg[7:0];
                    `ADCS_OFS_DMACTL:  o_rdata <= {7'h00, dma_off_reg};
                    `ADCS_OFS_SEL0:    o_rdata <= sel_reg[7:0];
                    `ADCS_OFS_SEL1:    o_rdata <= sel_reg[15:8];
                    `ADCS_OFS_SEL2:    o_rdata <= sel_reg[23:16];
                    `ADCS_OFS_SEL3:    o_rdata <= sel_reg[31:24];
                    default:           o_rdata <= 8'h00;
                endcase
            end else begin
                o_rdata <= 8'h00;
            end
        end
    end

    assign o_irq_done  = done_reg && ctrl1_reg[`ADCS_C1_DONE_IE];   // RULE5 RULE25
    assign o_irq_alarm = alarm_reg && ctrl1_reg[`ADCS_C1_ALARM_IE]; // RULE25
    assign o_irq_lost  = lost_reg && ctrl1_reg[`ADCS_C1_LOST_IE];   // RULE25
    assign o_irq_any   = o_irq_done || o_irq_alarm || o_irq_lost;   // RULE25

endmodule // adcs_sequencer

/* dv/adcs_sequencer_asserts.sv */
`timescale 1ns/1ns
module adcs_sequencer_asserts (
    input wire logic i_mclk,      // Clock
    input wire logic i_rst,       // Reset
    input wire logic i_wr,        // Write strobe
    input wire logic o_power_on,  // Power state
    input wire logic o_sampling,  // Sampling
    input wire logic o_conv_req,  // Conversion request
    input wire logic i_conv_done, // Conversion end
    input wire logic o_dma_req,   // DMA request
    input wire logic i_dma_ack,   // DMA ack
    input wire logic o_irq_done,  // Done interrupt
    input wire logic o_irq_alarm, // Alarm interrupt
    input wire logic o_irq_lost,  // Lost interrupt
    input wire logic o_irq_any    // Common interrupt
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    logic conv_busy_reg;
    // Busy from request until the core answers or power drops
    always_ff @(posedge i_mclk)
        if (i_rst || i_conv_done || !o_power_on) conv_busy_reg <= 1'b0;
        else if (o_conv_req) conv_busy_reg <= 1'b1;
    sequence s_req_once; o_conv_req ##1 !o_conv_req; endsequence
    sequence s_after_sample; $past(o_sampling) || $past(o_sampling, 2); endsequence
    power_gate_a: assert property (!o_power_on |-> !o_sampling)
        else $error("sampling while powered down");
    req_pulse_a: assert property ($rose(o_conv_req) |-> s_req_once)
        else $error("conversion request longer than one cycle");
    req_cause_a: assert property (o_conv_req |-> s_after_sample)
        else $error("conversion request without sampling");
    busy_hold_a: assert property (conv_busy_reg |-> !o_sampling)
        else $error("new sampling while converting");
    done_cause_a: assert property ($rose(o_irq_done) |-> $past(i_conv_done) || $past(i_wr))
        else $error("done interrupt without conversion end");
    dma_cause_a: assert property ($rose(o_dma_req) |-> $past(i_conv_done))
        else $error("DMA request without conversion end");
    dma_clear_a: assert property (o_dma_req && i_dma_ack && !i_conv_done |=> !o_dma_req)
        else $error("DMA request not cleared by ack");
    lost_cause_a: assert property ($rose(o_irq_lost) |-> ($past(o_dma_req) && $past(i_conv_done)) || $past(i_wr))
        else $error("lost interrupt without pending request");
    alarm_cause_a: assert property ($rose(o_irq_alarm) |-> $past(i_conv_done) || $past(i_wr))
        else $error("alarm interrupt without conversion end");
    irq_any_a: assert property (o_irq_any == (o_irq_done || o_irq_alarm || o_irq_lost))
        else $error("common interrupt differs from individual lines");
endmodule // adcs_sequencer_asserts

bind adcs_sequencer adcs_sequencer_asserts u_asserts (.i_mclk(i_mclk), .i_rst(i_rst), .i_wr(i_wr),
    .o_power_on(o_power_on), .o_sampling(o_sampling), .o_conv_req(o_conv_req), .i_conv_done(i_conv_done),
    .o_dma_req(o_dma_req), .i_dma_ack(i_dma_ack), .o_irq_done(o_irq_done), .o_irq_alarm(o_irq_alarm),
    .o_irq_lost(o_irq_lost), .o_irq_any(o_irq_any));

/* dv/adcs_core_model.sv */
`timescale 1ns/1ns
module adcs_core_model (
    input  wire logic        i_mclk,             // Clock
    input  wire logic        i_rst,              // Reset
    input  wire logic        i_conv_req,         // Conversion request
    input  wire logic [4:0]  i_chan,             // Channel converted
    input  wire logic [11:0] i_val,              // Upper result bits
    input  wire logic        i_dma_req,          // DMA request
    input  wire logic        i_ack_en,           // DMA serves requests
    output logic             o_conv_done = 1'b0, // Conversion end
    output logic [11:0]      o_conv_data = 12'h000, // Result
    output logic             o_dma_ack = 1'b0    // DMA took result
);
    int cnt;
    always @(posedge i_mclk) begin
        o_conv_done <= 1'b0;
        // Data is only valid with the done pulse, so it wanders otherwise
        o_conv_data <= i_rst ? 12'h000 : ~o_conv_data;
        if (i_rst) cnt <= 0;
        else if (i_conv_req) cnt <= 3;
        else if (cnt == 1) begin
            cnt <= 0;
            o_conv_done <= 1'b1;
            o_conv_data <= {i_val[11:5], i_chan};
        end
        else if (cnt != 0) cnt <= cnt - 1;
        o_dma_ack <= !i_rst && i_dma_req && i_ack_en && !o_dma_ack;
    end
endmodule // adcs_core_model

/* dv/adcs_sequencer_tb.sv */
`timescale 1ns/1ns
module adcs_sequencer_tb;
    logic        i_mclk = 1'b0;
    logic        i_rst = 1'b1;
    logic [7:0]  i_addr = 8'h00;
    logic [7:0]  i_wdata = 8'h00;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic [3:0]  pins = 4'h0;
    logic        i_trig_remap = 1'b0;
    logic [11:0] conv_val = 12'h000;
    logic        ack_en = 1'b1;
    logic        rd_pend = 1'b0;
    wire  [7:0]  o_rdata;
    wire  [4:0]  o_conv_channel;
    wire  [11:0] o_result, i_conv_data;
    wire         o_power_on, o_sampling, o_conv_req, i_conv_done, o_dma_req, i_dma_ack;
    wire         o_irq_done, o_irq_alarm, o_irq_lost, o_irq_any;
    int          mismatches = 0, compares = 0, cycles = 0, nconv = 0, done_at = 0, slen = 0, last_len = 0;
    int          seed = 32'hb5ae1b4f;
    logic [7:0]  exp_q[$];
    // Per row: select offset, select bits, ctrl2, ctrl3, channel, sample ticks
    logic [7:0]  tbl [5][6] = '{'{8'h0b, 8'h05, 8'h00, 8'h00, 8'h02, 8'h04},
        '{8'h0b, 8'h05, 8'h30, 8'h00, 8'h02, 8'h09}, '{8'h0e, 8'h02, 8'h00, 8'h40, 8'h19, 8'h10},
        '{8'h0d, 8'h80, 8'h60, 8'he0, 8'h17, 8'h18}, '{8'h0b, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04}};
    always #10 i_mclk = ~i_mclk;
    adcs_sequencer u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_trig_pin_dflt(pins[0]), .i_trig_pin_alt(pins[1]),
        .i_trig_remap(i_trig_remap), .i_first_timer_trigger_out(pins[2]), .i_second_timer_trigger_out(pins[3]), .o_power_on(o_power_on),
        .o_adc_clk_en(), .o_conv_channel(o_conv_channel), .o_sampling(o_sampling), .o_conv_req(o_conv_req),
        .i_conv_done(i_conv_done), .i_conv_data(i_conv_data), .o_result(o_result), .o_dma_req(o_dma_req),
        .i_dma_ack(i_dma_ack), .o_irq_done(o_irq_done), .o_irq_alarm(o_irq_alarm), .o_irq_lost(o_irq_lost),
        .o_irq_any(o_irq_any));
    adcs_core_model u_core (.i_mclk(i_mclk), .i_rst(i_rst), .i_conv_req(o_conv_req), .i_chan(o_conv_channel),
        .i_val(conv_val), .i_dma_req(o_dma_req), .i_ack_en(ack_en), .o_conv_done(i_conv_done),
        .o_conv_data(i_conv_data), .o_dma_ack(i_dma_ack));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        while (o_irq_done !== 1'b1 && n < 3000) begin
            @(posedge i_mclk);
            n++;
        end
        chk(n < 3000, 1);
    endtask
    always @(posedge i_mclk) begin
        cycles++;
        rd_pend <= i_rd;
        if (o_conv_req === 1'b1) nconv++;
        if (o_sampling === 1'b1) slen++;
        else if (slen != 0) begin
            last_len = slen;
            slen = 0;
        end
        if (cycles == 60000) begin
            mismatches++;
            report_and_stop();
        end
    end
    always @(posedge o_irq_done) done_at = nconv;
    always @(negedge i_mclk)
        if (rd_pend) chk(o_rdata, exp_q.pop_front());
    initial begin
        int i, j, s, e, r, k, h;
        logic [11:0] d;
        repeat (20) @(posedge i_mclk);
        i_rst <= 1'b0;
        rd(8'h00, 8'h00);
        rd(8'h03, 8'h00);
        rd(8'h06, 8'h0f);
        rd(8'h07, 8'hff);
        rd(8'h08, 8'h00);
        rd(8'h30, 8'h00);
        $display("test reset values done");
        wr(8'h0a, 8'h01);
        wr(8'h00, 8'h01);
        repeat (10) @(posedge i_mclk);
        for (i = 0; i < 5; i++) begin
            for (j = 0; j < 4; j++) wr(8'(8'h0b + j), 8'h00);
            wr(tbl[i][0], tbl[i][1]);
            wr(8'h01, tbl[i][2]);
            wr(8'h02, tbl[i][3]);
            conv_val <= $random(seed);
            wr(8'h00, 8'h0b);
            wait_done();
            d = {conv_val[11:5], tbl[i][4][4:0]};
            h = tbl[i][2][4];
            chk(o_result, d);
            chk((last_len + h) >> h, tbl[i][5]);
            rd(8'h00, 8'h09);
            rd(8'h03, 8'h01);
            rd(8'h04, {4'h0, d[11:8]});
            rd(8'h05, d[7:0]);
            rd(8'h03, 8'h00);
        end
        $display("test single done");
        wr(8'h0a, 8'h00);
        for (j = 0; j < 4; j++) wr(8'(8'h0b + j), 8'h00);
        wr(8'h0b, 8'h15);
        wr(8'h01, 8'h00);
        wr(8'h06, 8'h08);
        wr(8'h07, 8'h00);
        conv_val <= 12'hfe0;
        for (i = 0; i < 2; i++) begin
            ack_en <= (i == 0);
            wr(8'h02, i ? 8'h02 : 8'h05);
            wr(8'h03, 8'h07);
            j = nconv;
            wr(8'h00, 8'h2b);
            wait_done();
            chk(done_at - j, 3);
            repeat (20) @(posedge i_mclk);
            chk(nconv - j, 3);
            rd(8'h03, i ? 8'h07 : 8'h01);
            chk(o_irq_lost, i);
            chk(o_irq_any, 1);
        end
        ack_en <= 1'b1;
        wr(8'h03, 8'h07);
        j = nconv;
        wr(8'h00, 8'h0f);
        repeat (100) @(posedge i_mclk);
        wr(8'h00, 8'h09);
        repeat (100) @(posedge i_mclk);
        chk((nconv - j) % 3, 0);
        chk(nconv - j > 3, 1);
        wr(8'h03, 8'h07);
        wr(8'h00, 8'h0b);
        wr(8'h00, 8'h00);
        repeat (30) @(posedge i_mclk);
        rd(8'h03, 8'h00);
        $display("test scan done");
        wr(8'h0a, 8'h01);
        wr(8'h0b, 8'h01);
        wr(8'h00, 8'h09);
        repeat (10) @(posedge i_mclk);
        for (i = 0; i < 24; i++) begin
            s = i % 3;
            e = (i / 3) % 4;
            r = i / 12;
            k = (s == 0) ? r : s + 1;
            i_trig_remap <= r[0];
            wr(8'h01, {4'h0, e[1:0], s[1:0]});
            j = nconv;
            repeat (4) begin
                pins <= 4'($random(seed)) & ~(4'h1 << k);
                repeat (12) @(posedge i_mclk);
            end
            pins <= 4'h0;
            repeat (12) @(posedge i_mclk);
            pins[k] <= 1'b1;
            repeat (30) @(posedge i_mclk);
            pins[k] <= 1'b0;
            repeat (30) @(posedge i_mclk);
            chk(nconv - j, e[0] + e[1]);
        end
        $display("test triggers done");
        repeat (3) @(posedge i_mclk);
        report_and_stop();
    end
endmodule // adcs_sequencer_tb
